/* hw/health_event_smi_sci_enable.v */
// health event smi/sci routing: critical status, routing enables and interrupt outputs
`include "health_event_smi_sci_enable_defines.vh"
`default_nettype none

module health_event_smi_sci_enable (
  input wire I_CLK,
  input wire I_NRST,
  // register port
  input wire [7:0] I_REG_ADDR,
  input wire I_REG_WR,
  input wire I_REG_RD,
  input wire [7:0] I_REG_WDATA,
  output reg [7:0] O_REG_RDATA,
  // live critical temperature levels, one per zone
  input wire [2:0] I_ZONE_CRITICAL,
  // event flags from the measurement side
  input wire [7:0] I_LIMIT_EVENT_FLAGS,
  input wire [7:0] I_FAULT_EVENT_FLAGS,
  // routing selects
  input wire I_CRITICAL_ROUTE_SELECT,
  input wire I_LIMIT_ROUTE_SELECT,
  // interrupt outputs toward the chipset, then the routed flag views
  output reg O_SMI,
  output reg O_SCI,
  output reg [7:0] O_LIMIT_ROUTED,
  output reg [7:0] O_FAULT_ROUTED
);

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  wire sel_status;
  wire sel_limit_en;
  wire sel_fault_en;
  wire wr_limit_en;
  wire wr_fault_en;

  assign sel_status = hit(I_REG_ADDR, `CRITICAL_TEMP_STATUS_OFFSET);
  assign sel_limit_en = hit(I_REG_ADDR, `LIMIT_EVENT_ROUTE_ENABLE_OFFSET);
  assign sel_fault_en = hit(I_REG_ADDR, `FAULT_EVENT_ROUTE_ENABLE_OFFSET);
  // the status register has no write path: writes to it fall away
  assign wr_limit_en = I_REG_WR & sel_limit_en;
  assign wr_fault_en = I_REG_WR & sel_fault_en;

  // --------------------------------------------------------------------------
  // critical temperature status
  // --------------------------------------------------------------------------
  reg [7:0] critical_temp_status;
  wire [7:0] next_critical_temp_status;
  wire zone_one_critical_flag;
  wire zone_two_critical_flag;
  wire zone_three_critical_flag;

  assign zone_one_critical_flag = I_ZONE_CRITICAL[0];
  assign zone_two_critical_flag = I_ZONE_CRITICAL[1];
  assign zone_three_critical_flag = I_ZONE_CRITICAL[2];

  // live level, not sticky: a zone back at or below its limit reads 0
  assign next_critical_temp_status = {5'h00,
                                      zone_three_critical_flag,
                                      zone_two_critical_flag,
                                      zone_one_critical_flag};

  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      critical_temp_status <= `CRITICAL_TEMP_STATUS_RESET;
    end else begin
      critical_temp_status <= next_critical_temp_status;
    end
  end

  // --------------------------------------------------------------------------
  // routing enable registers
  // --------------------------------------------------------------------------
  wire [7:0] limit_event_route_enable;
  wire [7:0] fault_event_route_enable;

  // bit 7 of the first register is held at zero by the mask
  enable_reg8 #(
    .RESET_VALUE(`LIMIT_EVENT_ROUTE_ENABLE_RESET),
    .WRITE_MASK(`LIMIT_EVENT_ROUTE_ENABLE_MASK)
  ) u_limit_enable (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_wr(wr_limit_en),
    .i_wdata(I_REG_WDATA),
    .o_value(limit_event_route_enable)
  );

  enable_reg8 #(
    .RESET_VALUE(`FAULT_EVENT_ROUTE_ENABLE_RESET),
    .WRITE_MASK(`FAULT_EVENT_ROUTE_ENABLE_MASK)
  ) u_fault_enable (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_wr(wr_fault_en),
    .i_wdata(I_REG_WDATA),
    .o_value(fault_event_route_enable)
  );

  // --------------------------------------------------------------------------
  // named enable fields
  // --------------------------------------------------------------------------
  wire zone_three_route_enable;
  wire zone_two_route_enable;
  wire zone_one_route_enable;
  wire five_volt_route_enable;
  wire three_three_volt_route_enable;
  wire core_rail_route_enable;
  wire two_five_volt_route_enable;
  wire second_link_route_enable;
  wire diode_route_enable;
  wire fan_four_route_enable;
  wire fan_three_route_enable;
  wire fan_two_route_enable;
  wire fan_one_route_enable;
  wire first_link_route_enable;
  wire twelve_volt_route_enable;

  assign zone_three_route_enable = limit_event_route_enable[`ZONE_THREE_LIMIT_BIT];
  assign zone_two_route_enable = limit_event_route_enable[`ZONE_TWO_LIMIT_BIT];
  assign zone_one_route_enable = limit_event_route_enable[`ZONE_ONE_LIMIT_BIT];
  assign five_volt_route_enable = limit_event_route_enable[`FIVE_VOLT_BIT];
  assign three_three_volt_route_enable = limit_event_route_enable[`THREE_THREE_VOLT_BIT];
  assign core_rail_route_enable = limit_event_route_enable[`CORE_RAIL_BIT];
  assign two_five_volt_route_enable = limit_event_route_enable[`TWO_FIVE_VOLT_BIT];
  assign second_link_route_enable = fault_event_route_enable[`SECOND_LINK_BIT];
  assign diode_route_enable = fault_event_route_enable[`DIODE_FAULT_BIT];
  assign fan_four_route_enable = fault_event_route_enable[`FAN_FOUR_BIT];
  assign fan_three_route_enable = fault_event_route_enable[`FAN_THREE_BIT];
  assign fan_two_route_enable = fault_event_route_enable[`FAN_TWO_BIT];
  assign fan_one_route_enable = fault_event_route_enable[`FAN_ONE_BIT];
  assign first_link_route_enable = fault_event_route_enable[`FIRST_LINK_BIT];
  assign twelve_volt_route_enable = fault_event_route_enable[`TWELVE_VOLT_BIT];

  // --------------------------------------------------------------------------
  // named event flags
  // --------------------------------------------------------------------------
  wire zone_three_limit_event;
  wire zone_two_limit_event;
  wire zone_one_limit_event;
  wire five_volt_limit_event;
  wire three_three_volt_limit_event;
  wire core_rail_limit_event;
  wire two_five_volt_limit_event;
  wire second_link_fault_event;
  wire diode_fault_event;
  wire fan_four_stall_event;
  wire fan_three_stall_event;
  wire fan_two_stall_event;
  wire fan_one_stall_event;
  wire first_link_fault_event;
  wire twelve_volt_limit_event;

  assign zone_three_limit_event = I_LIMIT_EVENT_FLAGS[`ZONE_THREE_LIMIT_BIT];
  assign zone_two_limit_event = I_LIMIT_EVENT_FLAGS[`ZONE_TWO_LIMIT_BIT];
  assign zone_one_limit_event = I_LIMIT_EVENT_FLAGS[`ZONE_ONE_LIMIT_BIT];
  assign five_volt_limit_event = I_LIMIT_EVENT_FLAGS[`FIVE_VOLT_BIT];
  assign three_three_volt_limit_event = I_LIMIT_EVENT_FLAGS[`THREE_THREE_VOLT_BIT];
  assign core_rail_limit_event = I_LIMIT_EVENT_FLAGS[`CORE_RAIL_BIT];
  assign two_five_volt_limit_event = I_LIMIT_EVENT_FLAGS[`TWO_FIVE_VOLT_BIT];
  assign second_link_fault_event = I_FAULT_EVENT_FLAGS[`SECOND_LINK_BIT];
  assign diode_fault_event = I_FAULT_EVENT_FLAGS[`DIODE_FAULT_BIT];
  assign fan_four_stall_event = I_FAULT_EVENT_FLAGS[`FAN_FOUR_BIT];
  assign fan_three_stall_event = I_FAULT_EVENT_FLAGS[`FAN_THREE_BIT];
  assign fan_two_stall_event = I_FAULT_EVENT_FLAGS[`FAN_TWO_BIT];
  assign fan_one_stall_event = I_FAULT_EVENT_FLAGS[`FAN_ONE_BIT];
  assign first_link_fault_event = I_FAULT_EVENT_FLAGS[`FIRST_LINK_BIT];
  assign twelve_volt_limit_event = I_FAULT_EVENT_FLAGS[`TWELVE_VOLT_BIT];

  // --------------------------------------------------------------------------
  // grouping into the two routing classes
  // --------------------------------------------------------------------------
  // the twelve volt event lives in the fault register but is a limit event,
  // so it rides with the limit select; bit 7 of the limit class is that event
  wire [7:0] limit_class_flags;
  wire [7:0] limit_class_enables;
  wire [6:0] crit_class_flags;
  wire [6:0] crit_class_enables;

  assign limit_class_flags = {twelve_volt_limit_event,
                              zone_three_limit_event,
                              zone_two_limit_event,
                              zone_one_limit_event,
                              five_volt_limit_event,
                              three_three_volt_limit_event,
                              core_rail_limit_event,
                              two_five_volt_limit_event};

  assign limit_class_enables = {twelve_volt_route_enable,
                                zone_three_route_enable,
                                zone_two_route_enable,
                                zone_one_route_enable,
                                five_volt_route_enable,
                                three_three_volt_route_enable,
                                core_rail_route_enable,
                                two_five_volt_route_enable};

  assign crit_class_flags = {second_link_fault_event,
                             diode_fault_event,
                             fan_four_stall_event,
                             fan_three_stall_event,
                             fan_two_stall_event,
                             fan_one_stall_event,
                             first_link_fault_event};

  assign crit_class_enables = {second_link_route_enable,
                               diode_route_enable,
                               fan_four_route_enable,
                               fan_three_route_enable,
                               fan_two_route_enable,
                               fan_one_route_enable,
                               first_link_route_enable};

  // --------------------------------------------------------------------------
  // routing to smi or sci
  // --------------------------------------------------------------------------
  wire [7:0] limit_routed;
  wire [6:0] crit_routed;
  wire limit_smi_req;
  wire limit_sci_req;
  wire crit_smi_req;
  wire crit_sci_req;

  route_merge #(
    .WIDTH(8)
  ) u_limit_route (
    .i_flags(limit_class_flags),
    .i_enables(limit_class_enables),
    .i_select_sci(I_LIMIT_ROUTE_SELECT),
    .o_routed(limit_routed),
    .o_smi_req(limit_smi_req),
    .o_sci_req(limit_sci_req)
  );

  route_merge #(
    .WIDTH(7)
  ) u_crit_route (
    .i_flags(crit_class_flags),
    .i_enables(crit_class_enables),
    .i_select_sci(I_CRITICAL_ROUTE_SELECT),
    .o_routed(crit_routed),
    .o_smi_req(crit_smi_req),
    .o_sci_req(crit_sci_req)
  );

  // --------------------------------------------------------------------------
  // interrupt outputs and routed flag views
  // --------------------------------------------------------------------------
  wire next_smi;
  wire next_sci;
  wire [7:0] next_limit_routed;
  wire [7:0] next_fault_routed;

  // outputs are levels: they follow the flags, and the flag source clears them
  assign next_smi = limit_smi_req | crit_smi_req;
  assign next_sci = limit_sci_req | crit_sci_req;
  // routed views in register bit order for debug and wake logging
  assign next_limit_routed = {1'b0, limit_routed[6:0]};
  assign next_fault_routed = {crit_routed, limit_routed[7]};

  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SMI <= 1'b0;
      O_SCI <= 1'b0;
      O_LIMIT_ROUTED <= 8'h00;
      O_FAULT_ROUTED <= 8'h00;
    end else begin
      O_SMI <= next_smi;
      O_SCI <= next_sci;
      O_LIMIT_ROUTED <= next_limit_routed;
      O_FAULT_ROUTED <= next_fault_routed;
    end
  end

  // --------------------------------------------------------------------------
  // register read
  // --------------------------------------------------------------------------
  reg [7:0] next_reg_rdata;

  // unmapped offsets read zero, keeping the map tolerant of probing software
  always @* begin
    next_reg_rdata = `UNMAPPED_READ_VALUE;
    case (1'b1)
      sel_status: begin
        next_reg_rdata = critical_temp_status;
      end
      sel_limit_en: begin
        next_reg_rdata = limit_event_route_enable;
      end
      sel_fault_en: begin
        next_reg_rdata = fault_event_route_enable;
      end
      default: begin
        next_reg_rdata = `UNMAPPED_READ_VALUE;
      end
    endcase
  end

  // read data holds between reads so a slow host may sample it late
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_REG_RDATA <= 8'h00;
    end else if (I_REG_RD) begin
      O_REG_RDATA <= next_reg_rdata;
    end
  end

endmodule // health_event_smi_sci_enable

`default_nettype wire

/* inc/health_event_smi_sci_enable_defines.vh */
// register offsets, field positions and reset values of the health event routing block
`ifndef HEALTH_EVENT_SMI_SCI_ENABLE_DEFINES_VH
`define HEALTH_EVENT_SMI_SCI_ENABLE_DEFINES_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CRITICAL_TEMP_STATUS_OFFSET 8'h0b
`define LIMIT_EVENT_ROUTE_ENABLE_OFFSET 8'h0c
`define FAULT_EVENT_ROUTE_ENABLE_OFFSET 8'h0d

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CRITICAL_TEMP_STATUS_RESET 8'h00
`define LIMIT_EVENT_ROUTE_ENABLE_RESET 8'h00
`define FAULT_EVENT_ROUTE_ENABLE_RESET 8'h00
`define UNMAPPED_READ_VALUE 8'h00

// ----------------------------------------------------------------------------
// writable bit masks (reserved bits read as zero, writes to them dropped)
// ----------------------------------------------------------------------------
`define LIMIT_EVENT_ROUTE_ENABLE_MASK 8'h7f
`define FAULT_EVENT_ROUTE_ENABLE_MASK 8'hff

// ----------------------------------------------------------------------------
// critical status fields
// ----------------------------------------------------------------------------
`define ZONE_ONE_CRITICAL_BIT 0
`define ZONE_TWO_CRITICAL_BIT 1
`define ZONE_THREE_CRITICAL_BIT 2

// ----------------------------------------------------------------------------
// limit event route enable fields
// ----------------------------------------------------------------------------
`define TWO_FIVE_VOLT_BIT 0
`define CORE_RAIL_BIT 1
`define THREE_THREE_VOLT_BIT 2
`define FIVE_VOLT_BIT 3
`define ZONE_ONE_LIMIT_BIT 4
`define ZONE_TWO_LIMIT_BIT 5
`define ZONE_THREE_LIMIT_BIT 6

// ----------------------------------------------------------------------------
// fault event route enable fields
// ----------------------------------------------------------------------------
`define TWELVE_VOLT_BIT 0
`define FIRST_LINK_BIT 1
`define FAN_ONE_BIT 2
`define FAN_TWO_BIT 3
`define FAN_THREE_BIT 4
`define FAN_FOUR_BIT 5
`define DIODE_FAULT_BIT 6
`define SECOND_LINK_BIT 7

`endif

/* hw/enable_reg8.v */
// read/write enable register with a writable-bit mask
`default_nettype none

module enable_reg8 #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] WRITE_MASK = 8'hff
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_wr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_value
);

  // masked bits never leave their reset value, so reserved bits read zero
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_value <= RESET_VALUE;
    end else if (i_wr) begin
      o_value <= (i_wdata & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end
  end

endmodule // enable_reg8

`default_nettype wire

/* hw/route_merge.v */
// gates a group of event flags by enables and steers the result to smi or sci
`default_nettype none

module route_merge #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] i_flags,
  input wire [WIDTH-1:0] i_enables,
  input wire i_select_sci,
  output wire [WIDTH-1:0] o_routed,
  output wire o_smi_req,
  output wire o_sci_req
);

  wire any_routed;

  assign o_routed = i_flags & i_enables;
  assign any_routed = |o_routed;
  // select low sends the group to smi, high sends it to the sci wake path
  assign o_smi_req = any_routed & ~i_select_sci;
  assign o_sci_req = any_routed & i_select_sci;

endmodule // route_merge

`default_nettype wire

/* testbench/health_event_smi_sci_enable_asserts.sv */
// concurrent checks of the health event routing block
`include "health_event_smi_sci_enable_defines.vh"
`default_nettype none

module health_event_smi_sci_enable_asserts (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic [2:0] I_ZONE_CRITICAL,
  input wire logic [7:0] I_LIMIT_EVENT_FLAGS,
  input wire logic [7:0] I_FAULT_EVENT_FLAGS,
  input wire logic I_CRITICAL_ROUTE_SELECT,
  input wire logic I_LIMIT_ROUTE_SELECT,
  input wire logic O_SMI,
  input wire logic O_SCI,
  input wire logic [7:0] O_LIMIT_ROUTED,
  input wire logic [7:0] O_FAULT_ROUTED
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // shadow of the enables, rebuilt from the write strobes alone
  // ---------------------------------------------------------------
  logic [7:0] lim_en;
  logic [7:0] flt_en;
  logic lim_any;
  logic flt_any;
  logic smi_d;
  logic sci_d;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      lim_en <= 8'h00;
      flt_en <= 8'h00;
    end else if (I_REG_WR) begin
      if (I_REG_ADDR == `LIMIT_EVENT_ROUTE_ENABLE_OFFSET)
        lim_en <= I_REG_WDATA & `LIMIT_EVENT_ROUTE_ENABLE_MASK;
      if (I_REG_ADDR == `FAULT_EVENT_ROUTE_ENABLE_OFFSET)
        flt_en <= I_REG_WDATA;
    end
  end
  // the twelve volt fault bit joins the limit class
  assign lim_any = (|(I_LIMIT_EVENT_FLAGS & lim_en)) | (I_FAULT_EVENT_FLAGS[0] & flt_en[0]);
  assign flt_any = |(I_FAULT_EVENT_FLAGS[7:1] & flt_en[7:1]);
  assign smi_d = (lim_any & !I_LIMIT_ROUTE_SELECT) | (flt_any & !I_CRITICAL_ROUTE_SELECT);
  assign sci_d = (lim_any & I_LIMIT_ROUTE_SELECT) | (flt_any & I_CRITICAL_ROUTE_SELECT);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);
  sequence s_read(logic [7:0] a);
    I_REG_RD && (I_REG_ADDR == a);
  endsequence
  a_limit_gate: assert property (O_LIMIT_ROUTED == $past(I_LIMIT_EVENT_FLAGS & lim_en))
    else $error("limit routed flags wrong");
  a_fault_gate: assert property (O_FAULT_ROUTED == $past(I_FAULT_EVENT_FLAGS & flt_en))
    else $error("fault routed flags wrong");
  a_smi_level: assert property (O_SMI == $past(smi_d))
    else $error("smi level wrong");
  a_sci_level: assert property (O_SCI == $past(sci_d))
    else $error("sci level wrong");
  a_status_read: assert property (s_read(`CRITICAL_TEMP_STATUS_OFFSET) |=>
    O_REG_RDATA == {5'h00, $past(I_ZONE_CRITICAL, 2)}) else $error("status read wrong");
  a_limit_read: assert property (s_read(`LIMIT_EVENT_ROUTE_ENABLE_OFFSET) |=>
    O_REG_RDATA == $past(lim_en)) else $error("limit enable read wrong");
  a_fault_read: assert property (s_read(`FAULT_EVENT_ROUTE_ENABLE_OFFSET) |=>
    O_REG_RDATA == $past(flt_en)) else $error("fault enable read wrong");
  a_unmapped_read: assert property (I_REG_RD && !(I_REG_ADDR inside {8'h0b, 8'h0c, 8'h0d})
    |=> O_REG_RDATA == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
    else $error("read data moved without read");
endmodule // health_event_smi_sci_enable_asserts

bind health_event_smi_sci_enable health_event_smi_sci_enable_asserts chk_u (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR),
  .I_REG_RD(I_REG_RD), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
  .I_ZONE_CRITICAL(I_ZONE_CRITICAL), .I_LIMIT_EVENT_FLAGS(I_LIMIT_EVENT_FLAGS),
  .I_FAULT_EVENT_FLAGS(I_FAULT_EVENT_FLAGS), .I_CRITICAL_ROUTE_SELECT(I_CRITICAL_ROUTE_SELECT),
  .I_LIMIT_ROUTE_SELECT(I_LIMIT_ROUTE_SELECT), .O_SMI(O_SMI), .O_SCI(O_SCI),
  .O_LIMIT_ROUTED(O_LIMIT_ROUTED), .O_FAULT_ROUTED(O_FAULT_ROUTED));
`default_nettype wire

/* testbench/chipset_irq_sink.sv */
// chipset side model: takes smi and sci levels and counts each new request
`default_nettype none

module chipset_irq_sink (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_smi,
  input wire logic i_sci,
  output var int o_smi_count,
  output var int o_sci_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic smi_q;
  logic sci_q;
  // a level that stays high is one request, so only rising levels count
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      smi_q <= 1'b0;
      sci_q <= 1'b0;
      o_smi_count <= 0;
      o_sci_count <= 0;
    end else begin
      smi_q <= i_smi;
      sci_q <= i_sci;
      if (i_smi && !smi_q) o_smi_count <= o_smi_count + 1;
      if (i_sci && !sci_q) o_sci_count <= o_sci_count + 1;
    end
  end
endmodule // chipset_irq_sink
`default_nettype wire

/* testbench/test_health_event_smi_sci_enable.sv */
// self-checking bench of the health event routing block
`include "health_event_smi_sci_enable_defines.vh"
`default_nettype none

module test_health_event_smi_sci_enable;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, reg_wr, reg_rd, crit_sel, lim_sel, smi, sci;
  logic [7:0] reg_addr, reg_wdata, rdata, lim_flags, flt_flags, lim_routed, flt_routed;
  logic [2:0] zone_crit;
  int n_fail, samples_checked, smi_count, sci_count;

  health_event_smi_sci_enable dut_u (.I_CLK(clk), .I_NRST(nrst), .I_REG_ADDR(reg_addr),
    .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .I_REG_WDATA(reg_wdata), .O_REG_RDATA(rdata),
    .I_ZONE_CRITICAL(zone_crit), .I_LIMIT_EVENT_FLAGS(lim_flags),
    .I_FAULT_EVENT_FLAGS(flt_flags), .I_CRITICAL_ROUTE_SELECT(crit_sel),
    .I_LIMIT_ROUTE_SELECT(lim_sel), .O_SMI(smi), .O_SCI(sci),
    .O_LIMIT_ROUTED(lim_routed), .O_FAULT_ROUTED(flt_routed));
  chipset_irq_sink sink_u (.i_clk(clk), .i_nrst(nrst), .i_smi(smi), .i_sci(sci),
    .o_smi_count(smi_count), .o_sci_count(sci_count));

  always #5 clk = ~clk;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one-cycle strobes; read data is taken just after the edge that answers
  task automatic reg_acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    q = rdata;
  endtask
  task automatic drive_flags(input logic is_fault, input logic [7:0] f);
    @(posedge clk);
    lim_flags <= is_fault ? 8'h00 : f;
    flt_flags <= is_fault ? f : 8'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    logic [7:0] q;
    for (int a = 11; a < 14; a++) begin
      reg_acc(1'b0, 1'b1, 8'(a), 8'h00, q);
      check(q, 8'h00);
    end
    // every flag up: only the reset-cleared enables may keep the outputs low
    @(posedge clk);
    lim_flags <= 8'hff;
    flt_flags <= 8'hff;
    repeat (2) @(posedge clk);
    #1;
    check({6'h00, smi, sci}, 8'h00);
    check(lim_routed | flt_routed, 8'h00);
    @(posedge clk);
    lim_flags <= 8'h00;
    flt_flags <= 8'h00;
    $display("reset test done");
  endtask
  task automatic test_regs();
    logic [7:0] q;
    reg_acc(1'b1, 1'b0, 8'h0c, 8'hff, q);
    reg_acc(1'b1, 1'b1, 8'h0c, 8'h15, q);
    check(q, 8'h7f);
    reg_acc(1'b1, 1'b1, 8'h0d, 8'ha5, q);
    reg_acc(1'b0, 1'b1, 8'h0c, 8'h00, q);
    check(q, 8'h15);
    reg_acc(1'b1, 1'b1, 8'h0b, 8'hff, q);
    check(q, 8'h00);
    reg_acc(1'b0, 1'b1, 8'h0d, 8'h00, q);
    check(q, 8'ha5);
    reg_acc(1'b1, 1'b0, 8'h0e, 8'hff, q);
    reg_acc(1'b0, 1'b1, 8'h0e, 8'h00, q);
    check(q, 8'h00);
    reg_acc(1'b1, 1'b0, 8'h0c, 8'h00, q);
    reg_acc(1'b1, 1'b0, 8'h0d, 8'h00, q);
    $display("register test done");
  endtask
  task automatic test_status();
    logic [7:0] q;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      zone_crit <= (i < 3) ? 3'(1 << i) : ((i == 3) ? 3'h7 : 3'h0);
      reg_acc(1'b0, 1'b1, 8'h0b, 8'h00, q);
      check(q, (i < 3) ? 8'(1 << i) : ((i == 3) ? 8'h07 : 8'h00));
    end
    check(q, 8'h00);
    $display("status test done");
  endtask
  task automatic route_case(input logic is_fault, input int b, input logic sel);
    logic [7:0] m, q, ea;
    logic rc;
    m = 8'(1 << b);
    ea = is_fault ? 8'h0d : 8'h0c;
    rc = is_fault && (b != 0);
    @(posedge clk);
    crit_sel <= rc ? sel : !sel;
    lim_sel <= rc ? !sel : sel;
    reg_acc(1'b1, 1'b0, ea, m, q);
    drive_flags(is_fault, 8'hff);
    if (is_fault) check(flt_routed, m);
    else check(lim_routed, m);
    check({6'h00, smi, sci}, sel ? 8'h01 : 8'h02);
    drive_flags(is_fault, 8'h00);
    reg_acc(1'b1, 1'b0, ea, ~m, q);
    drive_flags(is_fault, m);
    check(is_fault ? flt_routed : lim_routed, 8'h00);
    check({6'h00, smi, sci}, 8'h00);
    drive_flags(is_fault, 8'h00);
    reg_acc(1'b1, 1'b0, ea, 8'h00, q);
  endtask
  task automatic test_routing();
    for (int s = 0; s < 2; s++) begin
      for (int b = 0; b < 7; b++) route_case(1'b0, b, s[0]);
      for (int b = 0; b < 8; b++) route_case(1'b1, b, s[0]);
    end
    check(8'(smi_count), 8'h0f);
    check(8'(sci_count), 8'h0f);
    $display("routing test done");
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    {clk, nrst, reg_wr, reg_rd, crit_sel, lim_sel} = 6'h00;
    {reg_addr, reg_wdata, lim_flags, flt_flags} = 32'h0;
    zone_crit = 3'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    test_reset();
    test_regs();
    test_status();
    test_routing();
    end_sim();
  end
  // whole run is under 1500 cycles; this allows several times that
  initial begin
    #100000;
    n_fail++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // test_health_event_smi_sci_enable
`default_nettype wire
